// file: src/ssint_pkg.sv
// Purpose: Shared constants for the interrupt endpoint protocol engine.
// Assumes: 250 MHz system clock; APB register access with 32-bit data.
// Notes: Packet kinds are carried as small codes on the link-side ports.
package ssint_pkg;
  localparam int CLK_MHZ = 250;
  localparam int BUS_INTERVAL_US = 125;
  localparam int BUS_INTERVAL_CYC = BUS_INTERVAL_US * CLK_MHZ;
  localparam int PING_TIMEOUT_US = 10;
  localparam int PING_TIMEOUT_CYC = PING_TIMEOUT_US * CLK_MHZ;
  localparam int MAX_BURST = 3;

  localparam int SEQ_W = 5;
  localparam logic [SEQ_W-1:0] SEQ_ONE = 5'h01;
  localparam logic [SEQ_W-1:0] SEQ_ZERO = 5'h00;

  localparam int KIND_W = 3;
  localparam logic [KIND_W-1:0] PKT_ACK = 3'h0;
  localparam logic [KIND_W-1:0] PKT_NRDY = 3'h1;
  localparam logic [KIND_W-1:0] PKT_ERDY = 3'h2;
  localparam logic [KIND_W-1:0] PKT_STALL = 3'h3;
  localparam logic [KIND_W-1:0] PKT_DATA = 3'h4;

  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 12'h000;
  localparam logic [ADDR_W-1:0] ADDR_STAT = 12'h004;
  localparam logic [ADDR_W-1:0] ADDR_INTV = 12'h008;

  localparam int CTRL_HALT = 0;
  localparam int CTRL_IN_READY = 1;
  localparam int CTRL_OUT_READY = 2;
  localparam int CTRL_REINIT = 3;
  localparam logic [3:0] CTRL_RESET = 4'h0;

  localparam int INTV_W = 4;
  localparam logic [INTV_W-1:0] INTV_RESET = 4'h0;

  localparam int STAT_IN_SEQ = 0;
  localparam int STAT_OUT_SEQ = 8;
  localparam int STAT_IN_FLOW = 16;
  localparam int STAT_OUT_FLOW = 17;
  localparam int STAT_HOLD = 18;
  localparam int STAT_COUNT = 20;
endpackage

// file: src/ssint_interval_timer.sv
// Purpose: Service interval tick from bus intervals of the system clock.
// Assumes: One clock; the exponent selects 2**exponent bus intervals.
// Notes: The tick is a one-cycle enable pulse from a flip-flop.
`timescale 1ns/1ps
module ssint_interval_timer #(
  parameter int BUS_CYC = ssint_pkg::BUS_INTERVAL_CYC
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [ssint_pkg::INTV_W-1:0] exponent,
  output logic sviTick
);
  import ssint_pkg::*;

  logic [31:0] busCnt_reg;
  logic [15:0] sviCnt_reg;
  logic busTick;
  logic [15:0] sviLast;

  generate
    if (BUS_CYC < 2) begin : g_chk
      $error("BUS_CYC must be at least 2");
    end
  endgenerate

  assign busTick = (busCnt_reg == 32'(BUS_CYC - 1));
  assign sviLast = 16'((32'h1 << exponent) - 32'h1);

  // Each bus interval lasts 125 us.
  always_ff @(posedge sys_clk) begin
    if (!rst_n || busTick) begin
      busCnt_reg <= 32'h0;
    end else begin
      busCnt_reg <= busCnt_reg + 32'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sviCnt_reg <= 16'h0;
      sviTick <= 1'b0;
    end else begin
      sviTick <= busTick && (sviCnt_reg >= sviLast);
      if (busTick) begin
        sviCnt_reg <= (sviCnt_reg >= sviLast) ? 16'h0 : sviCnt_reg + 16'h1;
      end
    end
  end
endmodule

// file: src/ssint_endpoint.sv
// Purpose: Device-side protocol engine for one interrupt IN and one OUT endpoint.
// Assumes: Link layer delivers decoded packets; inputs synchronous to sys_clk.
// Notes: APB answers with one wait state; unmapped addresses raise pslverr.
`timescale 1ns/1ps
module ssint_endpoint #(
  parameter int BUS_CYC = ssint_pkg::BUS_INTERVAL_CYC,
  parameter int PING_CYC = ssint_pkg::PING_TIMEOUT_CYC,
  parameter int BURST_LIMIT = ssint_pkg::MAX_BURST
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [ssint_pkg::ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rxValid,
  input wire logic [ssint_pkg::KIND_W-1:0] rxKind,
  input wire logic rxDirIn,
  input wire logic [ssint_pkg::SEQ_W-1:0] rxSeq,
  input wire logic [ssint_pkg::SEQ_W-1:0] rxNumP,
  input wire logic rxRetry,
  input wire logic rxDeferred,
  input wire logic rxPayloadOk,
  output logic rxReady,
  output logic txValid,
  output logic [ssint_pkg::KIND_W-1:0] txKind,
  output logic txDirIn,
  output logic [ssint_pkg::SEQ_W-1:0] txSeq,
  output logic [ssint_pkg::SEQ_W-1:0] txNumP,
  output logic txRetry,
  output logic txEob,
  input wire logic txReady,
  output logic linkHoldU0
);
  import ssint_pkg::*;

  typedef enum logic [0:0] {ST_IDLE, ST_BURST} ssint_state_e;

  generate
    if (BURST_LIMIT < 1 || BURST_LIMIT > 3) begin : g_chk
      $error("BURST_LIMIT must be 1 to 3");
    end
    if (PING_CYC < 1) begin : g_chk2
      $error("PING_CYC must be at least 1");
    end
  endgenerate

  localparam logic [1:0] BURST_MAX = 2'(BURST_LIMIT);

  ssint_state_e state_reg, state_next;
  logic [3:0] ctrl_reg;
  logic [INTV_W-1:0] intv_reg;
  logic [SEQ_W-1:0] inSeq_reg, outSeq_reg, burstSeq_reg;
  logic [1:0] burstLeft_reg, sviCount_reg;
  logic inFlow_reg, outFlow_reg;
  logic [31:0] pingCnt_reg;
  logic sviTick, rxFire, txFire, txFree, load;
  logic [KIND_W-1:0] loadKind;
  logic loadDirIn, loadRetry, loadEob;
  logic [SEQ_W-1:0] loadSeq, loadNumP;
  logic setHold, setInFlow, setOutFlow, clrInFlow, clrOutFlow, countPkt, startBurst, outAccept;
  logic [1:0] startLeft, room;
  logic apbAccess, apbHit;
  logic halt, inReady, outReady;

  assign halt = ctrl_reg[CTRL_HALT];
  assign inReady = ctrl_reg[CTRL_IN_READY];
  assign outReady = ctrl_reg[CTRL_OUT_READY];
  assign rxFire = rxValid && rxReady;
  assign txFire = txValid && txReady;
  assign txFree = !txValid || txFire;
  assign room = BURST_MAX - sviCount_reg;

  ssint_interval_timer #(
    .BUS_CYC(BUS_CYC)
  ) u_timer (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .exponent(intv_reg),
    .sviTick(sviTick)
  );

  // Decides the single response packet loaded into the transmit slot.
  always_comb begin
    load = 1'b0;
    loadKind = PKT_ACK;
    loadDirIn = 1'b0;
    loadSeq = SEQ_ZERO;
    loadNumP = SEQ_ZERO;
    loadRetry = 1'b0;
    loadEob = 1'b0;
    setHold = 1'b0;
    setInFlow = 1'b0;
    setOutFlow = 1'b0;
    clrInFlow = 1'b0;
    clrOutFlow = 1'b0;
    countPkt = 1'b0;
    startBurst = 1'b0;
    startLeft = 2'h0;
    outAccept = 1'b0;
    state_next = state_reg;
    if (rxFire && rxKind == PKT_ACK && rxDirIn) begin
      load = 1'b1;
      loadDirIn = 1'b1;
      if (halt) begin
        loadKind = PKT_STALL;
      end else if (rxDeferred) begin
        loadKind = inReady ? PKT_ERDY : PKT_NRDY;
        setHold = inReady;
        setInFlow = !inReady;
      end else if (!inReady) begin
        loadKind = PKT_NRDY;
        setInFlow = 1'b1;
      end else if (rxNumP == SEQ_ZERO || room == 2'h0) begin
        load = 1'b0;
      end else begin
        load = 1'b0;
        startBurst = 1'b1;
        startLeft = (rxNumP < SEQ_WIDEN(room)) ? rxNumP[1:0] : room;
        state_next = ST_BURST;
      end
    end else if (rxFire && rxKind == PKT_DATA && !rxDirIn) begin
      load = 1'b1;
      if (halt) begin
        loadKind = PKT_STALL;
      end else if (rxDeferred) begin
        loadKind = outReady ? PKT_ERDY : PKT_NRDY;
        setHold = outReady;
        setOutFlow = !outReady;
      end else if (!outReady) begin
        loadKind = PKT_NRDY;
        setOutFlow = 1'b1;
      end else if (!rxPayloadOk || rxSeq != outSeq_reg) begin
        loadSeq = outSeq_reg;
        loadNumP = SEQ_ONE;
        loadRetry = 1'b1;
      end else begin
        outAccept = 1'b1;
        countPkt = 1'b1;
        loadSeq = outSeq_reg + SEQ_ONE;
        loadNumP = (room > 2'h1) ? SEQ_WIDEN(room - 2'h1) : SEQ_ZERO;
      end
    end else if (state_reg == ST_BURST && txFree) begin
      load = 1'b1;
      loadKind = PKT_DATA;
      loadDirIn = 1'b1;
      loadSeq = burstSeq_reg;
      loadEob = (burstLeft_reg == 2'h1) && (sviCount_reg + 2'h1 == BURST_MAX);
      countPkt = 1'b1;
      if (burstLeft_reg == 2'h1) begin
        state_next = ST_IDLE;
      end
    end else if (state_reg == ST_IDLE && txFree && !rxValid) begin
      if (inFlow_reg && inReady && !halt) begin
        load = 1'b1;
        loadKind = PKT_ERDY;
        loadDirIn = 1'b1;
        clrInFlow = 1'b1;
      end else if (outFlow_reg && outReady && !halt) begin
        load = 1'b1;
        loadKind = PKT_ERDY;
        clrOutFlow = 1'b1;
      end
    end
  end

  function automatic logic [SEQ_W-1:0] SEQ_WIDEN(input logic [1:0] v);
    return {3'h0, v};
  endfunction

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      txValid <= 1'b0;
      txKind <= PKT_ACK;
      txDirIn <= 1'b0;
      txSeq <= SEQ_ZERO;
      txNumP <= SEQ_ZERO;
      txRetry <= 1'b0;
      txEob <= 1'b0;
    end else if (load) begin
      txValid <= 1'b1;
      txKind <= loadKind;
      txDirIn <= loadDirIn;
      txSeq <= loadSeq;
      txNumP <= loadNumP;
      txRetry <= loadRetry;
      txEob <= loadEob;
    end else if (txFire) begin
      txValid <= 1'b0;
    end
  end

  // Takes a new packet only while idle and the transmit slot stays free.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rxReady <= 1'b0;
    end else begin
      rxReady <= (state_next == ST_IDLE) && !load && !rxFire && (!txValid || txFire);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      burstSeq_reg <= SEQ_ZERO;
      burstLeft_reg <= 2'h0;
    end else if (ctrl_reg[CTRL_REINIT]) begin
      state_reg <= ST_IDLE;
      burstLeft_reg <= 2'h0;
    end else if (startBurst) begin
      state_reg <= state_next;
      burstSeq_reg <= rxSeq;
      burstLeft_reg <= startLeft;
    end else if (state_reg == ST_BURST && load) begin
      state_reg <= state_next;
      burstSeq_reg <= burstSeq_reg + SEQ_ONE;
      burstLeft_reg <= burstLeft_reg - 2'h1;
    end
  end

  // Sequence tracking; the five-bit OUT counter wraps from 31 to zero by itself, the IN value is copied from rxSeq.
  always_ff @(posedge sys_clk) begin
    if (!rst_n || ctrl_reg[CTRL_REINIT]) begin
      inSeq_reg <= SEQ_ZERO;
      outSeq_reg <= SEQ_ZERO;
    end else begin
      if (rxFire && rxKind == PKT_ACK && rxDirIn && !rxRetry && !rxDeferred) begin
        inSeq_reg <= rxSeq;
      end
      if (outAccept) begin
        outSeq_reg <= outSeq_reg + SEQ_ONE;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n || ctrl_reg[CTRL_REINIT]) begin
      sviCount_reg <= 2'h0;
    end else if (sviTick) begin
      sviCount_reg <= countPkt ? 2'h1 : 2'h0;
    end else if (countPkt && sviCount_reg != BURST_MAX) begin
      sviCount_reg <= sviCount_reg + 2'h1;
    end
  end

  // Flow-control flags; a new NRDY wins over the clear.
  always_ff @(posedge sys_clk) begin
    if (!rst_n || ctrl_reg[CTRL_REINIT]) begin
      inFlow_reg <= 1'b0;
      outFlow_reg <= 1'b0;
    end else begin
      inFlow_reg <= setInFlow || (inFlow_reg && !clrInFlow);
      outFlow_reg <= setOutFlow || (outFlow_reg && !clrOutFlow);
    end
  end

  // Holds the link in U0 until the next transaction or the ping timeout.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      linkHoldU0 <= 1'b0;
      pingCnt_reg <= 32'h0;
    end else if (setHold) begin
      linkHoldU0 <= 1'b1;
      pingCnt_reg <= 32'(PING_CYC);
    end else if (linkHoldU0) begin
      if (rxFire || pingCnt_reg == 32'h1) begin
        linkHoldU0 <= 1'b0;
      end
      pingCnt_reg <= pingCnt_reg - 32'h1;
    end
  end

  assign apbAccess = psel && penable && !pready;
  assign apbHit = (paddr == ADDR_CTRL) || (paddr == ADDR_STAT) || (paddr == ADDR_INTV);

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ctrl_reg <= CTRL_RESET;
      intv_reg <= INTV_RESET;
    end else begin
      ctrl_reg[CTRL_REINIT] <= 1'b0;
      if (apbAccess && pwrite && paddr == ADDR_CTRL) begin
        ctrl_reg <= pwdata[3:0];
      end
      if (apbAccess && pwrite && paddr == ADDR_INTV) begin
        intv_reg <= pwdata[INTV_W-1:0];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= apbAccess;
      pslverr <= apbAccess && !apbHit;
      prdata <= 32'h0;
      if (apbAccess && !pwrite) begin
        case (paddr)
          ADDR_CTRL: prdata <= {28'h0, ctrl_reg};
          ADDR_INTV: prdata <= {28'h0, intv_reg};
          ADDR_STAT: begin
            prdata[STAT_IN_SEQ +: SEQ_W] <= inSeq_reg;
            prdata[STAT_OUT_SEQ +: SEQ_W] <= outSeq_reg;
            prdata[STAT_IN_FLOW] <= inFlow_reg;
            prdata[STAT_OUT_FLOW] <= outFlow_reg;
            prdata[STAT_HOLD] <= linkHoldU0;
            prdata[STAT_COUNT +: 2] <= sviCount_reg;
          end
          default: prdata <= 32'h0;
        endcase
      end
    end
  end
endmodule

// file: sim/ssint_endpoint_properties.sv
// Purpose: Port checks for the interrupt endpoint engine.
// Assumes: Bound to ssint_endpoint; one clock.
// Notes: Counters bound burst length and U0 hold time.
`timescale 1ns/1ps
module ssint_endpoint_properties #(
  parameter int PING_CYC = 20,
  parameter int BURST_LIMIT = 3
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic rxValid,
  input wire logic [ssint_pkg::KIND_W-1:0] rxKind,
  input wire logic rxDirIn,
  input wire logic rxReady,
  input wire logic txValid,
  input wire logic [ssint_pkg::KIND_W-1:0] txKind,
  input wire logic [ssint_pkg::SEQ_W-1:0] txSeq,
  input wire logic txEob,
  input wire logic txReady,
  input wire logic linkHoldU0
);
  import ssint_pkg::*;
  int dpRun;
  int holdCnt;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  // Counts data packets sent since the last request was taken.
  always_ff @(posedge sys_clk) begin
    if (!rst_n || (rxValid && rxReady)) begin
      dpRun <= 0;
    end else if (txValid && txReady && txKind == PKT_DATA) begin
      dpRun <= dpRun + 1;
    end
  end
  always_ff @(posedge sys_clk) begin
    holdCnt <= (!rst_n || !linkHoldU0) ? 0 : holdCnt + 1;
  end
  sequence s_setup;
    psel && !penable ##1 psel && penable;
  endsequence
  sequence s_dp_more;
    txValid && txReady && txKind == PKT_DATA && !txEob;
  endsequence
  a_apb_one_wait: assert property (s_setup |-> !pready ##1 pready) else $error("apb wait state wrong");
  a_tx_hold: assert property (txValid && !txReady |=> txValid && $stable(txKind) && $stable(txSeq))
    else $error("tx packet changed before accept");
  a_seq_step: assert property (s_dp_more ##1 (txValid && txKind == PKT_DATA) |-> txSeq == $past(txSeq) + SEQ_ONE)
    else $error("sequence did not step by one");
  a_out_reply: assert property (rxValid && rxReady && rxKind == PKT_DATA && !rxDirIn |=> txValid)
    else $error("out packet not answered");
  a_rx_busy: assert property (rxValid && rxReady |=> !rxReady) else $error("rx taken twice");
  a_eob_data: assert property (txValid && txEob |-> txKind == PKT_DATA) else $error("eob off data");
  a_burst_cap: assert property (dpRun <= BURST_LIMIT) else $error("burst too long");
  a_hold_bound: assert property (holdCnt <= PING_CYC + 2) else $error("U0 hold too long");
endmodule
bind ssint_endpoint ssint_endpoint_properties #(.PING_CYC(PING_CYC), .BURST_LIMIT(BURST_LIMIT)) i_props (
  .sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pready(pready), .rxValid(rxValid),
  .rxKind(rxKind), .rxDirIn(rxDirIn), .rxReady(rxReady), .txValid(txValid), .txKind(txKind), .txSeq(txSeq),
  .txEob(txEob), .txReady(txReady), .linkHoldU0(linkHoldU0));

// file: sim/ssint_host_model.sv
// Purpose: Host controller model issuing interrupt packets.
// Assumes: One packet in flight; replies are queued for the bench.
// Notes: Slow mode withholds txReady half the time.
`timescale 1ns/1ps
module ssint_host_model (
  input wire logic sys_clk,
  input wire logic slow,
  input wire logic rxReady,
  output logic rxValid,
  output logic [ssint_pkg::KIND_W-1:0] rxKind,
  output logic rxDirIn,
  output logic [ssint_pkg::SEQ_W-1:0] rxSeq,
  output logic [ssint_pkg::SEQ_W-1:0] rxNumP,
  output logic rxRetry,
  output logic rxDeferred,
  output logic rxPayloadOk,
  input wire logic txValid,
  input wire logic [ssint_pkg::KIND_W-1:0] txKind,
  input wire logic txDirIn,
  input wire logic [ssint_pkg::SEQ_W-1:0] txSeq,
  input wire logic txRetry,
  input wire logic txEob,
  output logic txReady
);
  import ssint_pkg::*;
  logic [10:0] seen [$];
  logic [1:0] phase = 2'h0;
  initial begin
    {rxValid, rxKind, rxDirIn, rxSeq, rxNumP, rxRetry, rxDeferred, rxPayloadOk} = '0;
  end
  always @(posedge sys_clk) begin
    phase <= phase + 2'h1;
    if (txValid && txReady) begin
      seen.push_back({txKind, txDirIn, txSeq, txRetry, txEob});
    end
  end
  assign txReady = !slow || phase[1];
  // Holds one packet until taken, then scrambles its sequence and count fields.
  task automatic send(input logic [KIND_W-1:0] kind, input logic dirIn, input logic [SEQ_W-1:0] seq,
                      input logic [SEQ_W-1:0] numP, input logic defer, input logic ok);
    @(posedge sys_clk);
    {rxValid, rxKind, rxDirIn, rxSeq, rxNumP, rxDeferred, rxPayloadOk} <= {1'b1, kind, dirIn, seq, numP, defer, ok};
    @(posedge sys_clk);
    while (!rxReady) @(posedge sys_clk);
    {rxValid, rxSeq, rxNumP} <= {1'b0, ~seq, ~numP};
  endtask
endmodule

// file: sim/ssint_endpoint_tb.sv
// Purpose: Self-checking bench for the interrupt endpoint engine.
// Assumes: Short bus interval and ping timeout keep the run brief.
// Notes: Device replies are compared in arrival order.
`timescale 1ns/1ps
module ssint_endpoint_tb;
  import ssint_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic slowHost = 1'b0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata, q;
  logic pready, pslverr, err, rxValid, rxDirIn, rxRetry, rxDeferred, rxPayloadOk, rxReady;
  logic txValid, txDirIn, txRetry, txEob, txReady, linkHoldU0;
  logic [KIND_W-1:0] rxKind, txKind;
  logic [SEQ_W-1:0] rxSeq, rxNumP, txSeq, txNumP;
  logic [ADDR_W-1:0] regAddr [3] = '{ADDR_CTRL, ADDR_STAT, ADDR_INTV};
  int fail_count = 0;
  int checked = 0;
  int cycles = 0;
  always #2 sys_clk = ~sys_clk;
  ssint_endpoint #(.BUS_CYC(50), .PING_CYC(20), .BURST_LIMIT(3)) i_ssint_endpoint (
    .sys_clk(sys_clk), .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxValid(rxValid), .rxKind(rxKind),
    .rxDirIn(rxDirIn), .rxSeq(rxSeq), .rxNumP(rxNumP), .rxRetry(rxRetry), .rxDeferred(rxDeferred),
    .rxPayloadOk(rxPayloadOk), .rxReady(rxReady), .txValid(txValid), .txKind(txKind), .txDirIn(txDirIn),
    .txSeq(txSeq), .txNumP(txNumP), .txRetry(txRetry), .txEob(txEob), .txReady(txReady), .linkHoldU0(linkHoldU0));
  ssint_host_model i_ssint_host_model (
    .sys_clk(sys_clk), .slow(slowHost), .rxReady(rxReady), .rxValid(rxValid), .rxKind(rxKind), .rxDirIn(rxDirIn),
    .rxSeq(rxSeq), .rxNumP(rxNumP), .rxRetry(rxRetry), .rxDeferred(rxDeferred), .rxPayloadOk(rxPayloadOk),
    .txValid(txValid), .txKind(txKind), .txDirIn(txDirIn), .txSeq(txSeq), .txRetry(txRetry), .txEob(txEob),
    .txReady(txReady));
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      report_and_stop();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // One APB transfer; read data and error land in q and err.
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (!pready) @(posedge sys_clk);
    q = prdata;
    err = pslverr;
    {psel, penable} <= 2'h0;
  endtask
  // Takes the next reply; only DATA and ACK replies carry a sequence.
  task automatic expPkt(input logic [KIND_W-1:0] kind, input logic dirIn, input logic [SEQ_W-1:0] seq,
                        input logic rty, input logic eob);
    logic [10:0] got;
    logic [10:0] exp;
    got = 'x;
    exp = {kind, dirIn, seq, rty, eob};
    for (int n = 0; n < 300 && i_ssint_host_model.seen.size() == 0; n++) @(posedge sys_clk);
    if (i_ssint_host_model.seen.size() != 0) got = i_ssint_host_model.seen.pop_front();
    if (kind != PKT_DATA && kind != PKT_ACK) begin
      got[6:0] = 7'h00;
      exp[6:0] = 7'h00;
    end
    check({21'h0, got}, {21'h0, exp});
  endtask
  initial begin
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    foreach (regAddr[i]) begin
      apb(1'b0, regAddr[i], 32'h0);
      check(q, 32'h0);
    end
    apb(1'b0, 12'h00c, 32'h0);
    check({31'h0, err}, 32'h1);
    apb(1'b1, ADDR_INTV, 32'h1);
    apb(1'b0, ADDR_INTV, 32'h0);
    check(q, 32'h1);
    $display("test registers done");
    i_ssint_host_model.send(PKT_ACK, 1'b1, 5'h00, 5'h02, 1'b0, 1'b1);
    expPkt(PKT_NRDY, 1'b1, 5'h00, 1'b0, 1'b0);
    apb(1'b0, ADDR_STAT, 32'h0);
    check({31'h0, q[STAT_IN_FLOW]}, 32'h1);
    apb(1'b1, ADDR_CTRL, 32'h6);
    expPkt(PKT_ERDY, 1'b1, 5'h00, 1'b0, 1'b0);
    slowHost <= 1'b1;
    i_ssint_host_model.send(PKT_ACK, 1'b1, 5'h1f, 5'h03, 1'b0, 1'b1);
    expPkt(PKT_DATA, 1'b1, 5'h1f, 1'b0, 1'b0);
    expPkt(PKT_DATA, 1'b1, 5'h00, 1'b0, 1'b0);
    expPkt(PKT_DATA, 1'b1, 5'h01, 1'b0, 1'b1);
    slowHost <= 1'b0;
    i_ssint_host_model.send(PKT_ACK, 1'b1, 5'h02, 5'h00, 1'b0, 1'b1);
    apb(1'b0, ADDR_STAT, 32'h0);
    check({27'h0, q[STAT_IN_SEQ +: SEQ_W]}, 32'h2);
    $display("test in flow done");
    i_ssint_host_model.send(PKT_DATA, 1'b0, 5'h00, 5'h00, 1'b0, 1'b1);
    expPkt(PKT_ACK, 1'b0, 5'h01, 1'b0, 1'b0);
    i_ssint_host_model.send(PKT_DATA, 1'b0, 5'h01, 5'h00, 1'b0, 1'b0);
    expPkt(PKT_ACK, 1'b0, 5'h01, 1'b1, 1'b0);
    check({27'h0, txNumP}, 32'h1);
    apb(1'b1, ADDR_CTRL, 32'h2);
    i_ssint_host_model.send(PKT_DATA, 1'b0, 5'h01, 5'h00, 1'b0, 1'b1);
    expPkt(PKT_NRDY, 1'b0, 5'h00, 1'b0, 1'b0);
    apb(1'b1, ADDR_CTRL, 32'h6);
    expPkt(PKT_ERDY, 1'b0, 5'h00, 1'b0, 1'b0);
    i_ssint_host_model.send(PKT_DATA, 1'b0, 5'h01, 5'h00, 1'b0, 1'b1);
    expPkt(PKT_ACK, 1'b0, 5'h02, 1'b0, 1'b0);
    $display("test out flow done");
    i_ssint_host_model.send(PKT_ACK, 1'b1, 5'h02, 5'h01, 1'b1, 1'b1);
    expPkt(PKT_ERDY, 1'b1, 5'h00, 1'b0, 1'b0);
    check({31'h0, linkHoldU0}, 32'h1);
    repeat (30) @(posedge sys_clk);
    check({31'h0, linkHoldU0}, 32'h0);
    $display("test deferred done");
    apb(1'b1, ADDR_CTRL, 32'h1);
    i_ssint_host_model.send(PKT_ACK, 1'b1, 5'h02, 5'h01, 1'b0, 1'b1);
    expPkt(PKT_STALL, 1'b1, 5'h00, 1'b0, 1'b0);
    i_ssint_host_model.send(PKT_DATA, 1'b0, 5'h02, 5'h00, 1'b0, 1'b1);
    expPkt(PKT_STALL, 1'b0, 5'h00, 1'b0, 1'b0);
    apb(1'b1, ADDR_CTRL, 32'h8);
    apb(1'b0, ADDR_STAT, 32'h0);
    check(q & 32'h1f1f, 32'h0);
    apb(1'b1, ADDR_CTRL, 32'h6);
    i_ssint_host_model.send(PKT_ACK, 1'b1, 5'h00, 5'h01, 1'b0, 1'b1);
    expPkt(PKT_DATA, 1'b1, 5'h00, 1'b0, 1'b0);
    i_ssint_host_model.send(PKT_DATA, 1'b0, 5'h00, 5'h00, 1'b0, 1'b1);
    expPkt(PKT_ACK, 1'b0, 5'h01, 1'b0, 1'b0);
    $display("test stall and reinit done");
    report_and_stop();
  end
endmodule
